// ==== lda_loop_detect.sv ====
// loop detector switch decode, retune control, call output and apb slave
//
// Our own choices: the register offsets and the APB interface to the registers.
`default_nettype none
// Contract
// - level is sum of switch weights 1,2,4
// - level zero turns detection off
// - thresholds halve per level from 0.64%
// - call asserted about 30 ms after threshold
// - two band switches give band 0..3
// - band change alone never retunes
// - switch three on selects hold call
// - hold call at least four minutes
// - one 125 ms pulse per vehicle
// - absorb vehicle after two seconds occupancy
// - full sensitivity within one second after leaving
// - mode switch change retunes
// - sensitivity switch change retunes
// - tuned and running within two seconds
// - call when relative period drop exceeds threshold
// - loop failure forces call
// - pushbutton or power-up retunes
module lda_loop_detect
    import lda_pkg::*;
#(
    parameter int CW = 24, // period count width
    parameter int P_MS_CYC = MS_CYC, // cycles per ms tick
    parameter int P_HOLD_MS = HOLD_CALL_MS, // hold call time
    parameter int P_ABSORB_MS = ABSORB_MS // single shot tune-out
) (
    input wire logic i_ref_clk, // system clock
    input wire logic i_nrst, // async reset, active low
    input wire logic [5:0] i_dip_sw, // switches, bit n-1 = switch n
    input wire logic i_reset_btn_n, // pushbutton, active low
    input wire logic i_loop_fail, // loop failure level
    input wire logic [CW-1:0] i_period_cnt, // period count
    input wire logic i_period_vld, // count valid pulse
    input wire logic i_psel, // apb select
    input wire logic i_penable, // apb enable
    input wire logic i_pwrite, // apb direction
    input wire logic [7:0] i_paddr, // apb byte address
    input wire logic [31:0] i_pwdata, // apb write data
    output logic [31:0] o_prdata, // apb read data
    output logic o_pready, // apb ready
    output logic o_pslverr, // apb error
    output logic o_call, // call to controller
    output logic [1:0] o_band, // capacitor band select
    output logic o_tuning // tuning in progress
);
    // ========================================
    // declarations
    logic [7:0] meta; // first sync stage
    logic [7:0] sync; // second sync stage
    logic [5:0] sw_s; // synced switches
    logic btn_s; // synced button, active low
    logic fail_s; // synced loop failure
    logic [MS_W-1:0] ms_cnt; // time base divider
    logic tick; // one-cycle ms enable
    logic [5:0] sw_cand; // switch candidate
    logic [5:0] sw_deb; // debounced switches
    logic [CNT_W-1:0] deb_cnt; // settle counter
    logic deb_ok; // debounced value valid
    lda_cfg_t cur; // setting from debounced switches
    lda_cfg_t lat; // setting latched at last retune
    logic cfg_ok; // latched setting valid
    logic chg; // mode or level changed
    logic soft_rt; // software retune request
    logic retune; // any retune cause
    lda_state_t state; // tune or run
    logic [CNT_W-1:0] tmr; // tune wait counter
    logic tune_done; // tune wait elapsed
    logic [CW-1:0] ref_cnt; // reference period count
    logic [CW-1:0] samp; // last period count
    logic hit; // live sample over threshold
    logic hit_q; // last sample over threshold
    logic veh; // vehicle confirmed
    logic veh_q; // vehicle, one cycle late
    logic [CNT_W-1:0] conf; // confirm counter
    logic [CNT_W-1:0] occ; // occupancy counter
    logic [CNT_W-1:0] occ_lim; // tune-out time of the mode
    logic absorb; // tune the vehicle out
    logic pls; // single shot pulse active
    logic [CNT_W-1:0] pls_cnt; // pulse time left
    logic acc; // apb access phase
    logic [31:0] rd; // read mux
    logic rd_err; // unmapped address
    localparam lda_cfg_t CFG_RST = lda_decode(SW_RST); // setting at reset

    // relative drop test: (ref-s)/ref > (64/10000) / 2^(lvl-1)
    function automatic logic exceeds(input logic [CW-1:0] r,
                                     input logic [CW-1:0] s,
                                     input logic [2:0] lvl);
        logic [63:0] lhs;
        logic [63:0] rhs;
        lhs = 64'(r - s) * 64'(THR_DEN);
        rhs = 64'(r) * 64'(THR_NUM);
        lhs = lhs << (lvl - 3'd1);
        return (lvl != 3'd0) && (r > s) && (lhs > rhs);
    endfunction : exceeds

    // ========================================
    // pin synchronisers
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            meta <= 8'h40; // button idle high
            sync <= 8'h40;
        end else begin
            meta <= {i_loop_fail, i_reset_btn_n, i_dip_sw};
            sync <= meta;
        end
    end

    assign sw_s = sync[5:0];
    assign btn_s = sync[6];
    assign fail_s = sync[7];

    // ========================================
    // ms time base
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ms_cnt <= '0;
            tick <= 1'b0;
        end else if (ms_cnt == MS_W'(P_MS_CYC - 1)) begin
            ms_cnt <= '0;
            tick <= 1'b1;
        end else begin
            ms_cnt <= ms_cnt + 1'b1;
            tick <= 1'b0;
        end
    end

    // ========================================
    // switch debounce: value must stand DEB_MS
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sw_cand <= SW_RST;
            sw_deb <= SW_RST;
            deb_cnt <= '0;
            deb_ok <= 1'b0;
        end else if (sw_s != sw_cand) begin
            sw_cand <= sw_s; // restart settle time
            deb_cnt <= '0;
        end else if (deb_cnt == CNT_W'(DEB_MS)) begin
            sw_deb <= sw_cand;
            deb_ok <= 1'b1;
        end else if (tick) begin
            deb_cnt <= deb_cnt + 1'b1;
        end
    end

    // ========================================
    // retune causes; band is left out of the compare
    assign cur = lda_decode(sw_deb);
    assign chg = deb_ok && (!cfg_ok
        || cur.hold_call_setting != lat.hold_call_setting
        || cur.level != lat.level);
    assign retune = chg || !btn_s || soft_rt;

    // latch setting at each retune, band included
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            lat <= CFG_RST;
            cfg_ok <= 1'b0;
        end else if (retune && deb_ok) begin
            lat <= cur;
            cfg_ok <= 1'b1;
        end
    end

    // ========================================
    // tune / run state machine
    assign tune_done = cfg_ok && tmr >= CNT_W'(TUNE_MS);

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state <= st_tune; // power-up tunes first
            tmr <= '0;
        end else if (retune) begin
            state <= st_tune;
            tmr <= '0;
        end else begin
            unique case (state)
                st_tune: begin
                    if (tick && !tune_done) begin
                        tmr <= tmr + 1'b1;
                    end
                    if (tune_done && i_period_vld && !fail_s) begin
                        state <= st_run;
                    end
                end
                st_run: begin
                    tmr <= '0;
                end
            endcase
        end
    end

    // ========================================
    // reference tracking
    assign hit = exceeds(ref_cnt, i_period_cnt, lat.level);
    assign occ_lim = lat.hold_call_setting ? CNT_W'(P_HOLD_MS)
                                           : CNT_W'(P_ABSORB_MS);
    assign absorb = veh && occ >= occ_lim;

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ref_cnt <= '0;
            samp <= '0;
            hit_q <= 1'b0;
        end else if (retune) begin
            ref_cnt <= '0;
            hit_q <= 1'b0;
        end else if (i_period_vld && !fail_s) begin
            samp <= i_period_cnt;
            if (state == st_tune) begin
                hit_q <= 1'b0;
                if (tune_done) begin
                    ref_cnt <= i_period_cnt;
                end
            end else begin
                hit_q <= hit;
                if (absorb) begin
                    ref_cnt <= i_period_cnt;
                end else if (i_period_cnt > ref_cnt) begin
                    ref_cnt <= i_period_cnt;
                end else if (!hit && i_period_cnt < ref_cnt) begin
                    ref_cnt <= ref_cnt - 1'b1; // slow drift
                end
            end
        end
    end

    // ========================================
    // vehicle confirm and occupancy
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            veh <= 1'b0;
            conf <= '0;
            occ <= '0;
        end else if (retune || state != st_run || !hit_q) begin
            veh <= 1'b0;
            conf <= '0;
            occ <= '0;
        end else if (!veh) begin
            if (conf >= CNT_W'(CONF_MS)) begin
                veh <= 1'b1;
            end else if (tick) begin
                conf <= conf + 1'b1;
            end
        end else if (tick && occ < occ_lim) begin
            occ <= occ + 1'b1;
        end
    end

    // ========================================
    // single shot pulse, once per vehicle
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            veh_q <= 1'b0;
            pls <= 1'b0;
            pls_cnt <= '0;
        end else begin
            veh_q <= veh;
            if (retune) begin
                pls <= 1'b0;
                pls_cnt <= '0;
            end else if (veh && !veh_q) begin
                pls <= 1'b1;
                pls_cnt <= CNT_W'(PULSE_MS);
            end else if (pls && tick) begin
                pls_cnt <= pls_cnt - 1'b1;
                if (pls_cnt == CNT_W'(1)) begin
                    pls <= 1'b0;
                end
            end
        end
    end

    // ========================================
    // outputs
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_call <= 1'b0;
            o_band <= CFG_RST.band;
            o_tuning <= 1'b1;
        end else begin
            o_call <= fail_s
                || (lat.hold_call_setting ? veh : pls);
            o_band <= lat.band;
            o_tuning <= (state == st_tune);
        end
    end

    // ========================================
    // apb slave: one wait state per access
    assign acc = i_psel && i_penable;

    always_comb begin
        rd = '0;
        rd_err = 1'b0;
        unique case (i_paddr)
            ADDR_CTRL: rd = CTRL_RST; // retune bit reads zero
            ADDR_STAT: begin
                rd[ST_CALL] = o_call;
                rd[ST_VEH] = veh;
                rd[ST_TUNE] = (state == st_tune);
                rd[ST_FAIL] = fail_s;
                rd[ST_BAND_LSB +: 2] = lat.band;
                rd[ST_MODE] = lat.hold_call_setting;
                rd[ST_LVL_LSB +: 3] = lat.level;
                rd[ST_SW_LSB +: 6] = sw_deb;
            end
            ADDR_REF: rd = 32'(ref_cnt);
            ADDR_SAMP: rd = 32'(samp);
            default: rd_err = 1'b1; // unmapped
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_pready <= 1'b0;
            o_prdata <= '0;
            o_pslverr <= 1'b0;
        end else begin
            o_pready <= acc && !o_pready;
            o_pslverr <= acc && !o_pready && rd_err;
            if (acc && !o_pready && !i_pwrite) begin
                o_prdata <= rd_err ? '0 : rd;
            end
        end
    end

    // software retune: pulse on the completing write
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            soft_rt <= 1'b0;
        end else begin
            soft_rt <= acc && o_pready && i_pwrite
                && i_paddr == ADDR_CTRL && i_pwdata[CTRL_RETUNE];
        end
    end
endmodule : lda_loop_detect
`default_nettype wire

// ==== lda_loop_detect_props.sv ====
// checker of the loop detector port behaviour
`default_nettype none
module lda_loop_detect_props
    import lda_pkg::*;
#(
    parameter int P_MS_CYC = MS_CYC // cycles per ms tick
) (
    input wire logic i_ref_clk, // system clock
    input wire logic i_nrst, // async reset
    input wire logic [5:0] i_dip_sw, // switches
    input wire logic i_reset_btn_n, // pushbutton
    input wire logic i_loop_fail, // loop failure
    input wire logic i_psel, // apb select
    input wire logic i_penable, // apb enable
    input wire logic [7:0] i_paddr, // apb address
    input wire logic o_pready, // apb ready
    input wire logic o_pslverr, // apb error
    input wire logic o_call, // call output
    input wire logic [1:0] o_band, // band select
    input wire logic o_tuning // tuning flag
);
    timeunit 1ns;
    timeprecision 1ps;
    // ========================================
    // helper logic
    localparam int PL_MIN = (PULSE_MS - 1) * P_MS_CYC; // shortest pulse
    localparam int PL_MAX = PULSE_MS * P_MS_CYC + 2; // longest pulse
    localparam int TUNE_MAX = (DEB_MS + TUNE_MS + 3) * P_MS_CYC + 16;
    int call_len, tune_len; // cycles call and tuning have stood
    logic mapped; // address hits a register
    assign mapped = i_paddr inside {ADDR_CTRL, ADDR_STAT,
        ADDR_REF, ADDR_SAMP};
    // run lengths of call and tuning
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            call_len <= 0;
            tune_len <= 0;
        end else begin
            call_len <= o_call ? call_len + 1 : 0;
            tune_len <= o_tuning ? tune_len + 1 : 0;
        end
    end
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_nrst);
    // ========================================
    // properties
    property p_late; i_psel && i_penable && !o_pready |=> o_pready; endproperty
    a_late: assert property (p_late) else $error("ready not on time");
    property p_once; o_pready |=> !o_pready; endproperty
    a_once: assert property (p_once) else $error("ready too long");
    property p_unmap;
        i_psel && i_penable && !o_pready && !mapped |=> o_pslverr && o_pready;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped not refused");
    property p_fsafe; i_loop_fail [*4] |=> o_call; endproperty
    a_fsafe: assert property (p_fsafe) else $error("no failsafe");
    property p_btn; !i_reset_btn_n [*4] |=> o_tuning; endproperty
    a_btn: assert property (p_btn) else $error("button ignored");
    property p_band; $changed(o_band) |-> ##[0:3] o_tuning; endproperty
    a_band: assert property (p_band) else $error("band moved");
    property p_pulse;
        $fell(o_call) && !i_dip_sw[SW_MODE] && !o_tuning && !i_loop_fail
            |-> call_len >= PL_MIN && call_len <= PL_MAX;
    endproperty
    a_pulse: assert property (p_pulse) else $error("pulse length");
    property p_tune; o_tuning |-> tune_len <= TUNE_MAX; endproperty
    a_tune: assert property (p_tune) else $error("tuning too long");
    c_pulse: cover property ($fell(o_call) && !i_dip_sw[SW_MODE]);
    c_refused: cover property (o_pslverr);
    c_button: cover property ($fell(i_reset_btn_n));
endmodule : lda_loop_detect_props
bind lda_loop_detect lda_loop_detect_props #(.P_MS_CYC(P_MS_CYC))
    i_props (
    .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_dip_sw(i_dip_sw),
    .i_reset_btn_n(i_reset_btn_n), .i_loop_fail(i_loop_fail),
    .i_psel(i_psel), .i_penable(i_penable), .i_paddr(i_paddr),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .o_call(o_call),
    .o_band(o_band), .o_tuning(o_tuning)
);
`default_nettype wire

// ==== lda_loop_model.sv ====
// model of the loop oscillator: one period count per ms tick
`default_nettype none
module lda_loop_model
    import lda_pkg::*;
#(
    parameter int P_MS_CYC = MS_CYC, // cycles per count
    parameter logic [23:0] BASE = 24'h01_86a0 // count of the empty loop
) (
    input wire logic i_ref_clk, // system clock
    input wire logic i_nrst, // async reset, active low
    input wire logic [23:0] i_drop, // count drop while occupied
    output logic [23:0] o_cnt, // period count
    output logic o_vld // count valid pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    // ========================================
    // count source
    int div; // tick divider
    // one valid count a tick; between counts the bus toggles, not holds
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            div <= 0;
            o_vld <= 1'b0;
            o_cnt <= 24'h00_0000;
        end else begin
            div <= (div == P_MS_CYC - 1) ? 0 : div + 1;
            o_vld <= (div == 0);
            o_cnt <= (div == 0) ? BASE - i_drop : ~o_cnt;
        end
    end
endmodule : lda_loop_model
`default_nettype wire

// ==== lda_pkg.sv ====
// package of constants, types and decode helpers for the loop detector
`default_nettype none
package lda_pkg;
    // ========================================
    // clock and time base
    localparam int unsigned CLK_HZ = 50_000_000; // system clock rate
    localparam int unsigned TICK_MS = 1; // time base period in ms
    localparam int unsigned MS_CYC = CLK_HZ / 1000 * TICK_MS; // cycles
    localparam int unsigned MS_W = 16; // width of the time base counter
    localparam int unsigned CNT_W = 18; // width of the ms counters
    // ========================================
    // timing in ms
    localparam int unsigned DEB_MS = 10; // switch settle time
    localparam int unsigned TUNE_MS = 1000; // tune wait, under two seconds
    localparam int unsigned CONF_MS = 25; // call confirm, 30 +/- 10 ms
    localparam int unsigned PULSE_MS = 125; // single shot pulse length
    localparam int unsigned ABSORB_MS = 2000; // single shot tune-out
    localparam int unsigned HOLD_CALL_MS = 240_000; // hold call, 4 min
    // ========================================
    // threshold of level one as a fraction: 64 / 10000 = 0.64 %
    localparam int unsigned THR_NUM = 64;
    localparam int unsigned THR_DEN = 10_000;
    // ========================================
    // switch field positions (switch n sits at bit n-1, high = on)
    localparam int unsigned SW_BAND_LSB = 0; // switches 1 and 2
    localparam int unsigned SW_MODE = 2; // switch 3
    localparam int unsigned SW_SENS_LSB = 3; // switches 4, 5 and 6
    localparam logic [5:0] SW_RST = 6'h34; // factory settings
    // ========================================
    // register map, byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00; // control
    localparam logic [7:0] ADDR_STAT = 8'h04; // status
    localparam logic [7:0] ADDR_REF = 8'h08; // reference count
    localparam logic [7:0] ADDR_SAMP = 8'h0C; // last period count
    localparam int unsigned CTRL_RETUNE = 0; // write 1: retune
    localparam logic [31:0] CTRL_RST = 32'h0000_0000; // reset value
    localparam int unsigned ST_CALL = 0; // call output
    localparam int unsigned ST_VEH = 1; // vehicle confirmed
    localparam int unsigned ST_TUNE = 2; // tuning in progress
    localparam int unsigned ST_FAIL = 3; // loop failure
    localparam int unsigned ST_BAND_LSB = 4; // applied band, 2 bits
    localparam int unsigned ST_MODE = 6; // applied mode, 1 = hold call
    localparam int unsigned ST_LVL_LSB = 8; // applied level, 3 bits
    localparam int unsigned ST_SW_LSB = 16; // debounced switches, 6 bits
    // ========================================
    // types
    typedef struct packed {
        logic hold_call_setting; // 1: presence, 0: single shot
        logic [2:0] level; // sensitivity 0..7, 0 = off
        logic [1:0] band; // tuning band 0..3
    } lda_cfg_t;

    typedef enum logic {
        st_tune,
        st_run
    } lda_state_t;

    // turn the six switches into a setting
    function automatic lda_cfg_t lda_decode(input logic [5:0] sw);
        lda_cfg_t c;
        c.hold_call_setting = sw[SW_MODE];
        c.level = sw[SW_SENS_LSB +: 3];
        c.band = sw[SW_BAND_LSB +: 2];
        return c;
    endfunction : lda_decode
endpackage : lda_pkg
`default_nettype wire

// ==== tb_lda.sv ====
// self-checking bench of the loop detector
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
    miscompares++; $display("wrong value at %0t: %h, expected %h", \
    $time, a, b); end end
module tb
    import lda_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ========================================
    // settings and wires
    localparam int MS = 4; // cycles per ms tick in this run
    localparam int P_HOLD = 300; // shortened hold time
    localparam int P_ABSORB = 200; // shortened absorb time
    localparam int BASE = 32'h0001_86a0; // empty loop count
    localparam int LIMIT = 90_000; // run ceiling in cycles
    logic clk = 1'b0, nrst = 1'b0, btn_n = 1'b1, fail = 1'b0; // drives
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // apb control
    logic [5:0] sw = SW_RST; // switches
    logic [7:0] paddr = 8'h00; // apb address
    logic [31:0] pwdata = 32'h0000_0000, prdata, rdata; // apb data
    logic pready, pslverr, rerr, call, tuning, vld; // single outputs
    logic [1:0] band; // band select
    logic [23:0] cnt, drop = 24'h00_0000; // count and vehicle load
    int n, cyc = 0, miscompares = 0, checks_done = 0; // counters
    lda_loop_detect #(.CW(24), .P_MS_CYC(MS), .P_HOLD_MS(P_HOLD),
        .P_ABSORB_MS(P_ABSORB)) i_dut (
        .i_ref_clk(clk), .i_nrst(nrst), .i_dip_sw(sw),
        .i_reset_btn_n(btn_n), .i_loop_fail(fail), .i_period_cnt(cnt),
        .i_period_vld(vld), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .o_call(call), .o_band(band), .o_tuning(tuning)
    );
    lda_loop_model #(.P_MS_CYC(MS), .BASE(24'(BASE))) i_loop (
        .i_ref_clk(clk), .i_nrst(nrst), .i_drop(drop), .o_cnt(cnt),
        .o_vld(vld)
    );
    always #10 clk = ~clk;
    // ========================================
    // helpers
    function automatic logic [23:0] thr(input int l); // drop at threshold
        return 24'((BASE * THR_NUM / THR_DEN) >> (l - 1));
    endfunction : thr
    // one apb transfer, held until ready is seen
    task automatic apb(input logic w, input logic [7:0] a, input int d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1 && cyc < LIMIT);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wait_call(input logic v, input int lim); // n = wait
        n = 0;
        while (call !== v && n < lim) begin
            @(posedge clk);
            n++;
        end
    endtask : wait_call
    task automatic settle(); // debounce, then wait out tuning
        repeat ((DEB_MS + 1) * MS + 8) @(posedge clk);
        `CHK(tuning, 1'b1)
        n = 0;
        while (tuning !== 1'b0 && n < 1990 * MS) begin
            @(posedge clk);
            n++;
        end
        `CHK(tuning, 1'b0)
    endtask : settle
    task automatic test_done();
        $display("checks %0d, wrong %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            miscompares++;
            test_done();
        end
    end
    // ========================================
    // scenarios
    initial begin
        void'($urandom(78102));
        repeat (12) @(posedge clk);
        `CHK({tuning, band}, 3'b100)
        nrst <= 1'b1;
        settle();
        for (int l = 0; l < 8; l++) begin
            sw <= {3'(l), 1'b1, 2'b00};
            settle();
            apb(1'b0, ADDR_STAT, 0);
            `CHK(rdata[ST_LVL_LSB +: 3], 3'(l))
            `CHK(rdata[ST_MODE], 1'b1)
            drop <= (l == 0) ? 24'h00_0fff : thr(l);
            repeat (40 * MS) @(posedge clk);
            `CHK(call, 1'b0)
            drop <= 24'h00_0000;
            repeat (2 * MS) @(posedge clk);
            if (l != 0) begin
                drop <= thr(l) + 24'($urandom_range(1, thr(l)));
                wait_call(1'b1, 60 * MS);
                `CHK(n >= 20 * MS && n <= 40 * MS, 1'b1)
                `CHK(call, 1'b1)
                drop <= 24'h00_0000;
                wait_call(1'b0, 3 * MS);
            end
        end
        $display("levels tested");
        apb(1'b0, 8'h10, 0);
        `CHK({rerr, rdata}, {1'b1, 32'h0000_0000}) // unmapped refused
        apb(1'b1, ADDR_CTRL, 32'h0000_0001);
        settle();
        for (int b = 1; b < 5; b++) begin
            sw <= {3'h7, 1'b1, 2'(b)};
            repeat (20 * MS) @(posedge clk);
            `CHK({tuning, band}, {1'b0, 2'(b - 1)})
            btn_n <= 1'b0;
            repeat (5) @(posedge clk);
            btn_n <= 1'b1;
            settle();
            `CHK(band, 2'(b))
        end
        $display("bands tested");
        drop <= 24'h00_0100 + 24'($urandom_range(0, 255));
        wait_call(1'b1, 60 * MS);
        wait_call(1'b0, 400 * MS);
        `CHK(n >= (P_HOLD - 1) * MS && n <= (P_HOLD + 40) * MS, 1'b1)
        fail <= 1'b1;
        repeat (6) @(posedge clk);
        `CHK(call, 1'b1)
        fail <= 1'b0;
        drop <= 24'h00_0000;
        wait_call(1'b0, 3 * MS);
        `CHK(call, 1'b0)
        $display("hold and failure tested");
        sw <= {3'h7, 1'b0, 2'b00};
        settle();
        apb(1'b0, ADDR_STAT, 0);
        `CHK(rdata[ST_MODE], 1'b0)
        for (int v = 0; v < 2; v++) begin
            drop <= 24'h00_0100 + 24'($urandom_range(0, 255));
            wait_call(1'b1, 60 * MS);
            `CHK(call, 1'b1)
            wait_call(1'b0, 200 * MS);
            `CHK(n >= 124 * MS && n <= 126 * MS, 1'b1)
            wait_call(1'b1, 300 * MS);
            `CHK(call, 1'b0)
            drop <= 24'h00_0000;
            repeat (5 * MS) @(posedge clk);
        end
        $display("single shot tested");
        test_done();
    end
endmodule : tb
`default_nettype wire
